// [low_power_mode_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// - low-power modes: low-power regulator, no PLL/radio/RANDOM_NUMBER_GENERATOR
// - sleep: cpu clock stopped, resume within 9 cycles
// - stop 0: main regulator, flash off, wake 1.7us
// - stop modes accept the listed wakeup sources
// - stop clocks limited; 32 MHz follows radio demand
// - 16 MHz oscillator on by peripheral request
// - stop: serial receivers listen and raise wakeup
// - stop: two-wire address match raises wakeup
// - standby: both regulators off, flash off; few sources wake
// - shutdown: only rtc and wakeup pins wake
// - the two wakeup pins and rtc wake shutdown; standby also wakes on the reset pin
// - shutdown pin pulls discarded at exit
// - sram bank clocks gated separately in sleep
// - flash power-down only without radio, code in sram
// - io analog, trigger off, during and after reset
// - reset pin pull-up off for internal reset
module low_power_mode_sequencer #(
  parameter int STANDBY_WAKE  = lpm_pkg::STANDBY_WAKE_CYC,
  parameter int SHUTDOWN_WAKE = lpm_pkg::SHUTDOWN_WAKE_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // cpu requests
  input  wire logic       sleep_req_i,       // pulse: cpu enters low power
  input  wire logic [2:0] lp_sel_i,          // mode for sleep_req_i
  input  wire logic       lp_run_req_i,      // level: low-power run wanted
  input  wire logic       irq_i,             // any interrupt or event
  // software settings
  input  wire logic       flash_pd_req_i,
  input  wire logic       radio_in_use_i,
  input  wire logic       code_in_sram_i,
  input  wire logic       sram_a_gate_i,
  input  wire logic       sram_b_gate_i,
  input  wire logic       hse_sw_on_i,
  input  wire logic       hsi_sw_on_i,
  input  wire logic       io_cfg_apply_i,    // software takes pins out of analog
  input  wire logic       int_rst_src_i,     // reset came from inside
  // clock demands
  input  wire logic       radio_act_i,
  input  wire logic       hsi_periph_req_i,
  // wakeup sources
  input  wire logic       wake_reset_pin_i,
  input  wire logic       wake_io_i,
  input  wire logic       wake_radio_i,
  input  wire logic       wake_bor_i,
  input  wire logic       wake_pvd_i,
  input  wire logic       wake_pvm_i,
  input  wire logic       wake_rtc_i,
  input  wire logic       wake_independent_watchdog_i,
  input  wire logic       wake_comp_i,
  input  wire logic       serial_rx_evt_i,   // start, address or frame
  input  wire logic       i2c_addr_match_i,
  input  wire logic       wake_lptim_i,
  input  wire logic       wake_pin_a_i,
  input  wire logic       wake_pin_b_i,
  // power and clock controls
  output logic            main_regulator_o,
  output logic            low_power_regulator_o,
  output logic            cpu_clk_en_o,
  output logic            flash_on_o,
  output logic            flash_pd_o,
  output logic            sram_pwr_o,
  output logic            sram_a_clk_en_o,
  output logic            sram_b_clk_en_o,
  output logic            pll_allow_o,
  output logic            radio_avail_o,
  output logic            rng_avail_o,
  output logic            periph_run_o,
  output logic            stop_periph_en_o,
  output logic            backup_keep_o,
  output logic            stop_listen_o,
  output logic            wake_irq_o,
  output logic            hse_en_o,
  output logic            hsi_en_o,
  output logic            lsi_allow_o,
  output logic            pull_hold_o,
  output logic            io_analog_o,
  output logic            rst_pullup_o,
  output logic            wake_done_o
);

  localparam int TW = lpm_pkg::TIMER_W;

  // refuse counts the timer cannot hold
  if (STANDBY_WAKE < 2 || STANDBY_WAKE >= (1 << TW) ||
      SHUTDOWN_WAKE < 2 || SHUTDOWN_WAKE >= (1 << TW)) begin : g_chk
    $error("wake counts out of timer range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // state and timer
  lpm_pkg::pm_state_t state_reg;    // current mode
  lpm_pkg::pm_state_t state_next;
  logic               ret_lp_reg;   // wake returns to low-power run
  logic               ret_lp_next;
  logic               tmr_start;    // load the exit timer
  logic [TW-1:0]      tmr_load;
  logic               tmr_done;

  // wakeup source groups
  logic stop_wake;                  // any stop source
  logic stby_wake;                  // standby sources
  logic shdn_wake;                  // shutdown sources

  assign stop_wake = wake_reset_pin_i | wake_io_i | wake_radio_i | wake_bor_i
                   | wake_pvd_i | wake_pvm_i | wake_rtc_i | wake_independent_watchdog_i
                   | wake_comp_i | serial_rx_evt_i | i2c_addr_match_i | wake_lptim_i;
  assign stby_wake = wake_reset_pin_i | wake_pin_a_i | wake_pin_b_i
                   | wake_bor_i | wake_rtc_i | wake_independent_watchdog_i;
  assign shdn_wake = wake_pin_a_i | wake_pin_b_i | wake_rtc_i;

  wake_timer #(
    .W (TW)
  ) u_wake_timer (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .start_i  (tmr_start),
    .load_i   (tmr_load),
    .done_o   (tmr_done)
  );

  // mode entry from run or low-power run
  function automatic lpm_pkg::pm_state_t enter_mode(input logic [2:0] sel, input logic lp);
    case (sel)
      lpm_pkg::SEL_STOP0:    enter_mode = lpm_pkg::ST_STOP0;
      lpm_pkg::SEL_STOP1:    enter_mode = lpm_pkg::ST_STOP1;
      lpm_pkg::SEL_STANDBY:  enter_mode = lpm_pkg::ST_STANDBY;
      lpm_pkg::SEL_SHUTDOWN: enter_mode = lpm_pkg::ST_SHUTDOWN;
      default:               enter_mode = lp ? lpm_pkg::ST_LOW_POWER_SLEEP_MODE : lpm_pkg::ST_SLEEP;
    endcase
  endfunction : enter_mode

  // next mode and exit timing
  always_comb begin
    state_next  = state_reg;
    ret_lp_next = ret_lp_reg;
    tmr_start   = 1'b0;
    tmr_load    = '0;
    case (state_reg)
      lpm_pkg::ST_RUN: begin
        if (sleep_req_i) begin
          state_next = enter_mode(lp_sel_i, 1'b0);
        end else if (lp_run_req_i) begin
          state_next = lpm_pkg::ST_LOW_POWER_RUN_MODE;
        end
      end
      lpm_pkg::ST_LOW_POWER_RUN_MODE: begin
        if (sleep_req_i) begin
          state_next = enter_mode(lp_sel_i, 1'b1);
        end else if (!lp_run_req_i) begin
          state_next = lpm_pkg::ST_LPEXIT;
          tmr_start  = 1'b1;
          tmr_load   = TW'(lpm_pkg::LOW_POWER_RUN_MODE_EXIT_CYC - 1);
        end
      end
      lpm_pkg::ST_SLEEP, lpm_pkg::ST_LOW_POWER_SLEEP_MODE: begin
        if (irq_i) begin
          state_next  = lpm_pkg::ST_WAKE;
          ret_lp_next = (state_reg == lpm_pkg::ST_LOW_POWER_SLEEP_MODE);
          tmr_start   = 1'b1;
          tmr_load    = TW'(lpm_pkg::SLEEP_WAKE_CYC - 1);
        end
      end
      lpm_pkg::ST_STOP0: begin
        if (stop_wake) begin
          state_next  = lpm_pkg::ST_WAKE;
          ret_lp_next = 1'b0;
          tmr_start   = 1'b1;
          tmr_load    = TW'(lpm_pkg::STOP0_WAKE_CYC - 1);
        end
      end
      lpm_pkg::ST_STOP1: begin
        if (stop_wake) begin
          state_next  = lpm_pkg::ST_WAKE;
          ret_lp_next = 1'b0;
          tmr_start   = 1'b1;
          tmr_load    = TW'(lpm_pkg::STOP1_WAKE_CYC - 1);
        end
      end
      lpm_pkg::ST_STANDBY: begin
        if (stby_wake) begin
          state_next  = lpm_pkg::ST_WAKE;
          ret_lp_next = 1'b0;
          tmr_start   = 1'b1;
          tmr_load    = TW'(STANDBY_WAKE - 1);
        end
      end
      lpm_pkg::ST_SHUTDOWN: begin
        if (shdn_wake) begin
          state_next  = lpm_pkg::ST_WAKE;
          ret_lp_next = 1'b0;
          tmr_start   = 1'b1;
          tmr_load    = TW'(SHUTDOWN_WAKE - 1);
        end
      end
      lpm_pkg::ST_WAKE: begin
        if (tmr_done) begin
          state_next = ret_lp_reg ? lpm_pkg::ST_LOW_POWER_RUN_MODE : lpm_pkg::ST_RUN;
        end
      end
      lpm_pkg::ST_LPEXIT: begin
        if (tmr_done) begin
          state_next = lpm_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = lpm_pkg::ST_RUN;
      end
    endcase
  end

  // register mode
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg  <= lpm_pkg::ST_RUN;
      ret_lp_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ret_lp_reg <= ret_lp_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // controls decoded from the next mode
  logic [22:0] ctl_reg;   // all outputs, in the order of the output assign below
  logic [22:0] ctl_next;
  logic        is_stop;   // next mode is a stop level
  logic        flash_up;  // flash powered in next mode

  always_comb begin
    is_stop  = (state_next == lpm_pkg::ST_STOP0) || (state_next == lpm_pkg::ST_STOP1);
    flash_up = 1'b0;
    ctl_next = '0;
    ctl_next[13] = (state_next != lpm_pkg::ST_SHUTDOWN);            // bor, independent_watchdog kept
    ctl_next[18] = (state_next != lpm_pkg::ST_SHUTDOWN);
    ctl_next[5]  = (state_next != lpm_pkg::ST_SHUTDOWN);
    case (state_next)
      lpm_pkg::ST_RUN, lpm_pkg::ST_SLEEP: begin
        ctl_next[22] = 1'b1;                                        // main regulator
        ctl_next[2]  = (state_next == lpm_pkg::ST_RUN);
        flash_up     = 1'b1;
        ctl_next[8]  = 1'b1;
        ctl_next[9]  = 1'b1;
        ctl_next[10] = 1'b1;
        ctl_next[11] = 1'b1;
      end
      lpm_pkg::ST_LOW_POWER_RUN_MODE, lpm_pkg::ST_LOW_POWER_SLEEP_MODE: begin
        ctl_next[21] = 1'b1;
        ctl_next[2]  = (state_next == lpm_pkg::ST_LOW_POWER_RUN_MODE);
        flash_up     = 1'b1;
        ctl_next[11] = 1'b1;                                        // no pll, radio, rng
      end
      lpm_pkg::ST_STOP0: begin
        ctl_next[22] = 1'b1;
      end
      lpm_pkg::ST_STOP1: begin
        ctl_next[21] = 1'b1;
      end
      lpm_pkg::ST_WAKE: begin
        ctl_next[22] = !ret_lp_reg;
        ctl_next[21] = ret_lp_reg;
        flash_up     = 1'b1;
        ctl_next[11] = 1'b1;
      end
      lpm_pkg::ST_LPEXIT: begin
        ctl_next[22] = 1'b1;
        ctl_next[21] = 1'b1;
        ctl_next[2]  = 1'b1;
        flash_up     = 1'b1;
        ctl_next[11] = 1'b1;
      end
      default: begin
        ctl_next[22] = 1'b0;
      end
    endcase
    ctl_next[19] = flash_up;
    ctl_next[20] = flash_up && flash_pd_req_i && !radio_in_use_i
                   && code_in_sram_i;
    // bank clocks: on while cpu runs, gated on request in sleep
    ctl_next[17] = ctl_next[2] || (((state_next == lpm_pkg::ST_SLEEP) ||
                   (state_next == lpm_pkg::ST_LOW_POWER_SLEEP_MODE)) && !sram_a_gate_i);
    ctl_next[16] = ctl_next[2] || (((state_next == lpm_pkg::ST_SLEEP) ||
                   (state_next == lpm_pkg::ST_LOW_POWER_SLEEP_MODE)) && !sram_b_gate_i);
    ctl_next[12] = ctl_next[11] || is_stop;
    ctl_next[14] = is_stop;
    // wake interrupt: event seen while still in a stop level
    ctl_next[15] = ((state_reg == lpm_pkg::ST_STOP0) || (state_reg == lpm_pkg::ST_STOP1))
                   && (serial_rx_evt_i || i2c_addr_match_i);
    if (is_stop) begin
      ctl_next[7] = radio_act_i;
      ctl_next[6] = hsi_periph_req_i;
    end else if (ctl_next[11]) begin
      ctl_next[7] = hse_sw_on_i || radio_act_i;
      ctl_next[6] = hsi_sw_on_i || hsi_periph_req_i;
    end
    ctl_next[4] = (state_next == lpm_pkg::ST_SHUTDOWN);
    ctl_next[3] = ctl_reg[3] && !io_cfg_apply_i;
    ctl_next[1] = !int_rst_src_i;
    ctl_next[0] = tmr_done;
  end

  // register every output
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_reg    <= '0;
      ctl_reg[3] <= lpm_pkg::IO_ANALOG_RST;
      ctl_reg[1] <= lpm_pkg::RST_PULLUP_RST;
      ctl_reg[5] <= 1'b1;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign {main_regulator_o, low_power_regulator_o, flash_pd_o, flash_on_o,
          lsi_allow_o, sram_a_clk_en_o, sram_b_clk_en_o, wake_irq_o, stop_listen_o,
          backup_keep_o, stop_periph_en_o, periph_run_o, rng_avail_o, radio_avail_o,
          pll_allow_o, hse_en_o, hsi_en_o, sram_pwr_o, pull_hold_o, io_analog_o,
          cpu_clk_en_o, rst_pullup_o, wake_done_o} = ctl_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sleep_irq;
    (state_reg == lpm_pkg::ST_SLEEP) && irq_i;
  endsequence

  sequence s_cpu_back;
    ##[1:9] cpu_clk_en_o;
  endsequence

  a_sleep_resume_bound: assert property (
    @(posedge mclk_i) disable iff (!resetn_i) s_sleep_irq |-> s_cpu_back)
    else $error("sleep exit slower than 9 cycles");

  a_lp_no_pll: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    low_power_regulator_o && !main_regulator_o |-> !pll_allow_o && !radio_avail_o && !rng_avail_o)
    else $error("pll or radio offered on low-power regulator");

  a_stop0_wake_time: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (state_reg == lpm_pkg::ST_STOP0) && stop_wake |-> ##[1:425] cpu_clk_en_o)
    else $error("stop 0 exit too slow");

  a_stop_flash_off: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    $rose(stop_listen_o) |-> !flash_on_o && sram_pwr_o && !cpu_clk_en_o)
    else $error("stop entered with flash on");

  a_standby_io_ignored: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (state_reg == lpm_pkg::ST_STANDBY) && wake_io_i && !stby_wake
    |=> state_reg == lpm_pkg::ST_STANDBY)
    else $error("plain io woke standby");

  a_shutdown_pull_drop: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (state_reg == lpm_pkg::ST_SHUTDOWN) && shdn_wake |=> !pull_hold_o && sram_pwr_o)
    else $error("pin pulls kept after shutdown");

  a_flash_pd_guard: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    flash_pd_o |-> $past(code_in_sram_i) && !$past(radio_in_use_i) && flash_on_o)
    else $error("flash powered down while needed");

  a_sram_gate_sleep: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (state_next == lpm_pkg::ST_SLEEP) && sram_a_gate_i && !sram_b_gate_i
    |=> !sram_a_clk_en_o && sram_b_clk_en_o)
    else $error("sram bank clocks not gated apart");

  a_rst_pullup_src: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    int_rst_src_i |=> !rst_pullup_o)
    else $error("reset pull-up on for internal reset");

  a_io_analog_hold: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    io_analog_o && !io_cfg_apply_i |=> io_analog_o)
    else $error("io left analog without software");

  a_stop_hse_radio: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    is_stop && radio_act_i |=> hse_en_o ##0 stop_listen_o)
    else $error("32 MHz oscillator not engaged for radio");

endmodule : low_power_mode_sequencer
`default_nettype wire

// [low_power_mode_sequencer_test.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// self-checking bench of the power mode sequencer
module low_power_mode_sequencer_test;
  localparam int SB = 20;  // shortened standby and shutdown exits
  // mode outputs per mode: run, low_power_run_mode, sleep, low_power_sleep_mode, stop0, stop1, standby, shutdown
  localparam logic [10:0] EXP [8] = '{11'h5FC, 11'h3DC, 11'h4FC, 11'h2DC,
                                      11'h44E, 11'h24E, 11'h044, 11'h001};
  logic        mclk, resetn, sleep_req, lp_run_req, fire, io_apply, int_rst;
  logic [2:0]  lp_sel;     // requested low power mode
  logic [3:0]  src;        // model event source
  logic [7:0]  dly;        // model event delay
  logic [14:0] wk;         // wake lines, bit 14 is irq
  logic [2:0]  fl;         // flash pd request, radio in use, code in sram
  logic [1:0]  gate;       // sram bank clock gates
  logic [1:0]  sw_on;      // software oscillator enables
  logic [1:0]  dem;        // radio and peripheral clock demand
  logic        main, low_power_regulator, cpu, flash_on, flash_pd, sram_pwr, sram_a, sram_b, pll, radio, random_number_generator;
  logic        prun, stopp, bk, listen, fast_external_oscillator, hsi, slow_internal_oscillator, hold, io_an, rst_pu, wirq, done;
  int          n_errors, check_count, seed_val;
  int          cycles = 0; // timeout counter

  low_power_mode_sequencer #(.STANDBY_WAKE(SB), .SHUTDOWN_WAKE(SB)) uut (
    .mclk_i(mclk), .resetn_i(resetn), .sleep_req_i(sleep_req), .lp_sel_i(lp_sel),
    .lp_run_req_i(lp_run_req), .irq_i(wk[14]), .flash_pd_req_i(fl[2]),
    .radio_in_use_i(fl[1]), .code_in_sram_i(fl[0]), .sram_a_gate_i(gate[1]),
    .sram_b_gate_i(gate[0]), .hse_sw_on_i(sw_on[1]), .hsi_sw_on_i(sw_on[0]),
    .io_cfg_apply_i(io_apply), .int_rst_src_i(int_rst), .radio_act_i(dem[1]),
    .hsi_periph_req_i(dem[0]), .wake_reset_pin_i(wk[0]), .wake_io_i(wk[1]),
    .wake_radio_i(wk[2]), .wake_bor_i(wk[3]), .wake_pvd_i(wk[4]), .wake_pvm_i(wk[5]),
    .wake_rtc_i(wk[6]), .wake_independent_watchdog_i(wk[7]), .wake_comp_i(wk[8]),
    .serial_rx_evt_i(wk[9]), .i2c_addr_match_i(wk[10]), .wake_lptim_i(wk[11]),
    .wake_pin_a_i(wk[12]), .wake_pin_b_i(wk[13]), .main_regulator_o(main),
    .low_power_regulator_o(low_power_regulator), .cpu_clk_en_o(cpu), .flash_on_o(flash_on),
    .flash_pd_o(flash_pd), .sram_pwr_o(sram_pwr), .sram_a_clk_en_o(sram_a),
    .sram_b_clk_en_o(sram_b), .pll_allow_o(pll), .radio_avail_o(radio), .rng_avail_o(random_number_generator),
    .periph_run_o(prun), .stop_periph_en_o(stopp), .backup_keep_o(bk),
    .stop_listen_o(listen), .wake_irq_o(wirq), .hse_en_o(fast_external_oscillator), .hsi_en_o(hsi),
    .lsi_allow_o(slow_internal_oscillator), .pull_hold_o(hold), .io_analog_o(io_an), .rst_pullup_o(rst_pu),
    .wake_done_o(done));

  wake_source_model src_model (.mclk_i(mclk), .resetn_i(resetn), .fire_i(fire),
    .src_i(src), .delay_i(dly), .wake_o(wk));

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic final_report();
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // mode outputs packed in table order
  function automatic logic [10:0] outv();
    return {main, low_power_regulator, cpu, flash_on, sram_pwr, pll, prun, stopp, bk, listen, hold};
  endfunction : outv

  // cpu asks for a low power mode, outputs then checked against the table
  task automatic enter(input logic [2:0] sel, input int m);
    @(posedge mclk);
    sleep_req <= 1'b1;
    lp_sel    <= sel;
    @(posedge mclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    check(16'(outv()), 16'(EXP[m]));
  endtask : enter

  // wake through source s (15: leave low-power run), cycles from waking edge
  task automatic wake(input int s, input int n, input logic lp);
    int cnt;
    cnt = 0;
    @(posedge mclk);
    if (s < 15) begin
      fire <= 1'b1;
      src  <= 4'(s);
      dly  <= 8'($urandom_range(0, 20));
      @(posedge mclk);
      fire <= 1'b0;
      while (wk == 15'h0000 && cnt < 40) begin
        @(posedge mclk);
        #1;
        cnt++;
      end
      cnt = 0;
    end else lp_run_req <= 1'b0;
    do begin
      @(posedge mclk);
      #1;
      cnt++;
      if (cnt == 1) check(16'(wirq), 16'(s == 9 || s == 10));
    end while (!(cpu && (lp ? low_power_regulator : pll)) && cnt < 5000);
    check(16'(cnt), 16'(n));
    check(16'(done), 16'h0001);
  endtask : wake

  // a source that must not wake mode m leaves the mode unchanged
  task automatic refuse(input int s, input int m);
    @(posedge mclk);
    fire <= 1'b1;
    src  <= 4'(s);
    dly  <= 8'h00;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (30) @(posedge mclk);
    #1;
    check(16'(outv()), 16'(EXP[m]));
  endtask : refuse

  ////////////////////////////////////////////////////////////////////////////
  // clock and timeout
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      final_report();
    end
  end

  // main sequence
  initial begin
    {resetn, sleep_req, lp_run_req, fire, io_apply, int_rst} = 6'h00;
    {lp_sel, src, dly, fl, gate, sw_on, dem} = 24'h000000;
    n_errors    = 0;
    check_count = 0;
    seed_val    = $urandom(32'h7573A32D);
    repeat (4) @(posedge mclk);
    int_rst <= 1'($urandom);
    #1;
    check(16'({outv(), radio, random_number_generator}), 16'h0100);
    check(16'({io_an, rst_pu, slow_internal_oscillator}), 16'h0006);
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check(16'({outv(), radio, random_number_generator, io_an}), 16'({EXP[0], 3'h7}));
    check(16'(rst_pu), 16'(!int_rst));
    // software settings while running
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      fl      <= (i == 0) ? 3'h5 : 3'($urandom);
      int_rst <= 1'($urandom);
      repeat (2) @(posedge mclk);
      #1;
      check(16'(flash_pd), 16'(fl[2] & ~fl[1] & fl[0]));
      check(16'(rst_pu), 16'(!int_rst));
    end
    @(posedge mclk);
    fl       <= 3'h0;
    io_apply <= 1'b1;
    @(posedge mclk);
    io_apply <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check(16'(io_an), 16'h0000);
    // sleep from run, low-power sleep from low-power run
    for (int lp = 0; lp < 2; lp++) begin
      @(posedge mclk);
      lp_run_req <= 1'(lp);
      gate       <= 2'($urandom);
      sw_on      <= 2'($urandom);
      repeat (3) @(posedge mclk);
      #1;
      check(16'({outv(), radio, random_number_generator}), 16'({EXP[lp], lp ? 2'h0 : 2'h3}));
      enter(3'h0, 2 + lp);
      check(16'({sram_a, sram_b, radio, random_number_generator}), 16'({~gate, lp ? 2'h0 : 2'h3}));
      wake(14, lpm_pkg::SLEEP_WAKE_CYC, 1'(lp));
    end
    wake(15, lpm_pkg::LOW_POWER_RUN_MODE_EXIT_CYC, 1'b0);
    check(16'(outv()), 16'(EXP[0]));
    // both stop levels, every stop wake source once
    for (int s = 0; s < 12; s++) begin
      @(posedge mclk);
      sw_on <= 2'h0;
      dem   <= 2'($urandom);
      enter(3'(1 + s % 2), 4 + s % 2);
      check(16'({fast_external_oscillator, hsi}), 16'(dem));
      wake(s, (s % 2) ? lpm_pkg::STOP1_WAKE_CYC : lpm_pkg::STOP0_WAKE_CYC, 1'b0);
    end
    // standby then shutdown: a refused source, then a wakeup pin
    for (int k = 0; k < 2; k++) begin
      enter(3'(3 + k), 6 + k);
      refuse(k ? 3 : 1, 6 + k);
      wake(k ? 13 : 12, SB, 1'b0);
      check(16'(outv()), 16'(EXP[0]));
    end
    final_report();
  end
endmodule : low_power_mode_sequencer_test
`default_nettype wire

// [lpm_pkg.sv]
////////////////////////////////////////////////////////////////////////////////
// shared constants and types of the power mode sequencer
package lpm_pkg;

  // clock of the sequencer
  localparam real CLK_PERIOD_NS     = 4.0;

  // exit times in their own units
  localparam int  SLEEP_WAKE_CYC    = 9;       // sleep exit, in cpu cycles
  localparam real STOP0_WAKE_US     = 1.7;
  localparam real STOP1_WAKE_US     = 4.7;
  localparam real STANDBY_WAKE_US   = 51.0;
  localparam real LOW_POWER_RUN_MODE_EXIT_US     = 15.33;
  localparam real SHUTDOWN_WAKE_US  = 60.0;    // no figure given, plain default

  // longest times round down to whole cycles
  localparam int  STOP0_WAKE_CYC    = int'($floor(STOP0_WAKE_US * 1000.0 / CLK_PERIOD_NS));
  localparam int  STOP1_WAKE_CYC    = int'($floor(STOP1_WAKE_US * 1000.0 / CLK_PERIOD_NS));
  localparam int  STANDBY_WAKE_CYC  = int'($floor(STANDBY_WAKE_US * 1000.0 / CLK_PERIOD_NS));
  localparam int  LOW_POWER_RUN_MODE_EXIT_CYC    = int'($floor(LOW_POWER_RUN_MODE_EXIT_US * 1000.0 / CLK_PERIOD_NS));
  localparam int  SHUTDOWN_WAKE_CYC = int'($floor(SHUTDOWN_WAKE_US * 1000.0 / CLK_PERIOD_NS));

  // width of the exit timer
  localparam int  TIMER_W           = 16;

  // values after reset
  localparam logic IO_ANALOG_RST    = 1'b1;
  localparam logic RST_PULLUP_RST   = 1'b1;

  // low power mode picked on a sleep request
  typedef enum logic [2:0] {
    SEL_SLEEP    = 3'h0,
    SEL_STOP0    = 3'h1,
    SEL_STOP1    = 3'h2,
    SEL_STANDBY  = 3'h3,
    SEL_SHUTDOWN = 3'h4
  } lp_sel_t;

  // sequencer states, one-hot
  typedef enum logic [9:0] {
    ST_RUN      = 10'h001,
    ST_LOW_POWER_RUN_MODE    = 10'h002,
    ST_SLEEP    = 10'h004,
    ST_LOW_POWER_SLEEP_MODE  = 10'h008,
    ST_STOP0    = 10'h010,
    ST_STOP1    = 10'h020,
    ST_STANDBY  = 10'h040,
    ST_SHUTDOWN = 10'h080,
    ST_WAKE     = 10'h100,
    ST_LPEXIT   = 10'h200
  } pm_state_t;

endpackage : lpm_pkg

// [wake_source_model.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// wake sources and cpu events: one event pulse after a chosen delay
module wake_source_model (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        fire_i,    // arm one event
  input  wire logic [3:0]  src_i,     // which source fires, 14 is irq
  input  wire logic [7:0]  delay_i,   // cycles before the event
  output logic      [14:0] wake_o     // one-cycle event lines, idle low
);
  logic       armed;                  // event pending
  logic [7:0] left;                   // cycles still to wait
  logic [3:0] which;                  // latched source
  ////////////////////////////////////////////////////////////////////////////
  // prompt or slow answer, lines fall back to idle after one cycle
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed  <= 1'b0;
      left   <= 8'h00;
      which  <= 4'h0;
      wake_o <= 15'h0000;
    end else begin
      wake_o <= 15'h0000;
      if (fire_i) begin
        armed <= 1'b1;
        left  <= delay_i;
        which <= src_i;
      end else if (armed && left == 8'h00) begin
        armed         <= 1'b0;
        wake_o[which] <= 1'b1;
      end else if (armed) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule : wake_source_model
`default_nettype wire

// [wake_timer.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// down counter timing a mode exit; done is high in the last counted cycle
module wake_timer #(
  parameter int W = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic         start_i,   // load pulse
  input  wire logic [W-1:0] load_i,    // cycles until done
  output logic              done_o     // combinational, one cycle
);

  // refuse widths the down counter cannot serve
  if (W < 2) begin : g_chk
    $error("timer width too small");
  end

  logic [W-1:0] count_reg;  // remaining cycles, zero when idle
  logic [W-1:0] count_next;

  // load on start, else count down to zero
  always_comb begin
    count_next = count_reg;
    if (start_i) begin
      count_next = load_i;
    end else if (count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  // register the count
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // last cycle of the wait
  assign done_o = (count_reg == W'(1));

endmodule : wake_timer
`default_nettype wire
